// ==== src/pedf_top.sv ====
// Port error-detect flag register bank with APB access, capture and interrupt.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "pedf_cfg.svh"

// Function
// R01 - Set bit 12 when a received packet carries an unexpected ackID.
// R02 - Set bit 13 when a received packet fails CRC.
// R03 - Set bit 14 when a received packet exceeds 276 bytes.
// R04 - Set bit 26 when a link response names a non-outstanding ackID.
// R05 - On link-response mismatch, capture content is marked invalid.
// R06 - Recovery sends a link request to the partner.
// R07 - Partner answers with the ackID it expects next.
// R08 - Accepted acknowledge advances local ackID, readable in a status register.
// R09 - Mismatched ackIDs after recovery halt all transfers until realigned.
// R10 - Set bit 27 on a control symbol unexpected in current state.
// R11 - Set bit 29 on misaligned delimiter or undefined code-group.
// R12 - Delineation errors and timeouts leave capture registers unchanged.
// R13 - Set bit 30 on an unexpected acknowledge control symbol.
// R14 - Set bit 31 when acknowledge or link response times out.
// R15 - Flags stay set until written zero; writing one keeps; reset clears.
// R16 - Bits 15 to 25 and 28 read zero and ignore writes.
module pedf_top
  import pedf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pkt_end,
  input wire logic rx_pkt_ackid_bad,
  input wire logic rx_pkt_crc_bad,
  input wire logic [`PEDF_LEN_W-1:0] rx_pkt_bytes,
  input wire logic [31:0] rx_pkt_info,
  input wire logic rx_symbol_unexpected,
  input wire logic rx_framing_bad,
  input wire logic rx_ack_unexpected,
  input wire logic tx_pkt_sent,
  input wire logic rx_ack_accepted,
  input wire logic rx_link_rsp,
  input wire logic [`PEDF_ACKID_W-1:0] rx_link_rsp_ackid,
  output logic link_req,
  output logic tx_halt,
  output logic [31:0] error_flags,
  output logic irq
);
  pedf_ack_if ai ();

  logic [31:0] flags_ff;
  logic [31:0] istat_ff;
  logic [31:0] ien_ff;
  logic [31:0] capt_ff;
  logic capv_ff;
  logic [`PEDF_TMO_W-1:0] tmo_ff;
  logic kick_ff;
  logic load_ff;
  logic [`PEDF_ACKID_W-1:0] load_val_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic link_req_ff;
  logic tx_halt_ff;
  logic irq_ff;
  logic [31:0] ev;
  logic [31:0] nxt_flags;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr;
  logic pkt_err;
  logic oversize;

  pedf_ack_trk u_trk (
    .pclk(pclk),
    .presetn(presetn),
    .t(ai.trk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event collection.

  assign oversize = rx_pkt_end && (rx_pkt_bytes > `PEDF_MAX_PKT_BYTES); // R03
  assign pkt_err = rx_pkt_ackid_bad || rx_pkt_crc_bad || oversize;

  always_comb begin
    ev = '0;
    ev[`PEDF_BIT_SEQ] = rx_pkt_ackid_bad; // R01
    ev[`PEDF_BIT_CRC] = rx_pkt_crc_bad; // R02
    ev[`PEDF_BIT_SIZE] = oversize; // R03
    ev[`PEDF_BIT_RSEQ] = ai.rsp_bad; // R04
    // A link response outside recovery is itself an out-of-state symbol.
    ev[`PEDF_BIT_UNEXP] = rx_symbol_unexpected || (rx_link_rsp && !ai.awaiting); // R10
    ev[`PEDF_BIT_FRAME] = rx_framing_bad; // R11
    ev[`PEDF_BIT_STRAY] = rx_ack_unexpected || ai.ack_stray; // R13
    ev[`PEDF_BIT_TMO] = ai.tmo_exp; // R14
  end

  assign ai.tx_sent = tx_pkt_sent;
  assign ai.ack_accepted = rx_ack_accepted;
  assign ai.rsp_valid = rx_link_rsp && ai.awaiting;
  assign ai.rsp_ackid = rx_link_rsp_ackid;
  assign ai.sw_load = load_ff;
  assign ai.sw_ackid = load_val_ff;
  assign ai.recover_kick = kick_ff;
  assign ai.tmo_val = tmo_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data comes from a flop.

  assign wr = psel && penable && pwrite && pready_ff;

  always_comb begin
    nxt_rdata = '0;
    nxt_err = 1'b0;
    case (paddr)
      `PEDF_OFF_FLAGS: nxt_rdata = flags_ff;
      `PEDF_OFF_ACKID: nxt_rdata = {15'h0000, ai.halted, 3'h0, ai.next_tx, 3'h0,
        ai.acked}; // R08
      `PEDF_OFF_TMO: nxt_rdata = {8'h00, tmo_ff};
      `PEDF_OFF_CAPT: nxt_rdata = capt_ff;
      `PEDF_OFF_CAPV: nxt_rdata = {31'h0000_0000, capv_ff};
      `PEDF_OFF_ISTAT: nxt_rdata = istat_ff;
      `PEDF_OFF_ICLR: nxt_rdata = '0;
      `PEDF_OFF_IEN: nxt_rdata = ien_ff;
      `PEDF_OFF_CTRL: nxt_rdata = '0;
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= `PEDF_RST_WORD;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        prdata_ff <= pwrite ? '0 : nxt_rdata;
        pslverr_ff <= nxt_err;
      end else begin
        prdata_ff <= '0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags: write zero clears, write one keeps, a new event beats the clear.

  always_comb begin
    nxt_flags = flags_ff;
    if (wr && (paddr == `PEDF_OFF_FLAGS)) begin
      nxt_flags = flags_ff & pwdata; // R15
    end
    nxt_flags = (nxt_flags | ev) & `PEDF_FLAG_MASK; // R16
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `PEDF_RST_WORD; // R15
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture of the offending packet; only packet errors hold valid content.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_ff <= `PEDF_RST_WORD;
      capv_ff <= 1'b0;
    // Framing errors and timeouts carry no packet, so the last packet error stays captured.
    end else if (pkt_err) begin // R12
      capt_ff <= rx_pkt_info;
      capv_ff <= 1'b1;
    end else if (ai.rsp_bad) begin
      capv_ff <= 1'b0; // R05
    end else if (wr && (paddr == `PEDF_OFF_CAPV) && !pwdata[0]) begin
      capv_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control: timeout value, recovery kick and ackID realignment.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_ff <= `PEDF_RST_TMO;
    end else if (wr && (paddr == `PEDF_OFF_TMO)) begin
      tmo_ff <= pwdata[`PEDF_TMO_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_ff <= 1'b0;
      load_ff <= 1'b0;
      load_val_ff <= '0;
    end else begin
      kick_ff <= wr && (paddr == `PEDF_OFF_CTRL) && pwdata[0];
      load_ff <= wr && (paddr == `PEDF_OFF_ACKID);
      if (wr && (paddr == `PEDF_OFF_ACKID)) begin
        load_val_ff <= pwdata[`PEDF_ACKID_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= `PEDF_RST_WORD;
    end else if (wr && (paddr == `PEDF_OFF_ICLR)) begin
      istat_ff <= ((istat_ff & ~pwdata) | ev) & `PEDF_FLAG_MASK;
    end else begin
      istat_ff <= (istat_ff | ev) & `PEDF_FLAG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff <= `PEDF_RST_WORD;
    end else if (wr && (paddr == `PEDF_OFF_IEN)) begin
      ien_ff <= pwdata & `PEDF_FLAG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
      link_req_ff <= 1'b0;
      tx_halt_ff <= 1'b0;
    end else begin
      irq_ff <= |(istat_ff & ien_ff);
      link_req_ff <= ai.link_req; // R06
      tx_halt_ff <= ai.halted || ai.awaiting; // R09
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign link_req = link_req_ff;
  assign tx_halt = tx_halt_ff;
  assign error_flags = flags_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_flag_write_zero(int b);
    wr && (paddr == `PEDF_OFF_FLAGS) && !pwdata[b];
  endsequence

  AST_SEQ_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R01
    rx_pkt_ackid_bad |=> flags_ff[`PEDF_BIT_SEQ])
    else $error("Unexpected packet ackID did not set its flag.");
  AST_CRC_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R02
    rx_pkt_crc_bad |=> flags_ff[`PEDF_BIT_CRC] && capv_ff)
    else $error("Packet CRC error did not set its flag.");
  AST_SIZE_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R03
    rx_pkt_end && !flags_ff[`PEDF_BIT_SIZE]
    |=> flags_ff[`PEDF_BIT_SIZE] == ($past(rx_pkt_bytes) > `PEDF_MAX_PKT_BYTES))
    else $error("Oversize flag disagrees with packet length.");
  AST_RSEQ_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ai.rsp_bad |=> flags_ff[`PEDF_BIT_RSEQ] ##1 tx_halt_ff)
    else $error("Link response mismatch not flagged.");
  AST_CAPV_DROP: assert property (@(posedge pclk) disable iff (!presetn) // R05
    ai.rsp_bad && !pkt_err |=> !capv_ff)
    else $error("Capture still valid after link response mismatch.");
  AST_UNEXP_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R10
    rx_link_rsp && !ai.awaiting |=> flags_ff[`PEDF_BIT_UNEXP])
    else $error("Out-of-state link response not flagged.");
  AST_FRAME_KEEP_CAPT: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (rx_framing_bad || ai.tmo_exp) && !pkt_err && !(wr && (paddr == `PEDF_OFF_FLAGS))
    |=> $stable(capt_ff)
    && flags_ff[`PEDF_BIT_FRAME] == ($past(rx_framing_bad) || $past(flags_ff[29])))
    else $error("Framing or timeout disturbed the capture.");
  AST_FRAME_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R11
    rx_framing_bad |=> flags_ff[`PEDF_BIT_FRAME])
    else $error("Framing error not flagged.");
  AST_STRAY_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R13
    rx_ack_unexpected |=> flags_ff[`PEDF_BIT_STRAY])
    else $error("Unexpected acknowledge not flagged.");
  AST_TMO_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R14
    ai.tmo_exp |=> flags_ff[`PEDF_BIT_TMO] ##1 istat_ff[`PEDF_BIT_TMO])
    else $error("Timeout not flagged.");
  AST_W0C: assert property (@(posedge pclk) disable iff (!presetn) // R15
    s_flag_write_zero(`PEDF_BIT_CRC) and !rx_pkt_crc_bad |=> !flags_ff[`PEDF_BIT_CRC])
    else $error("Writing zero did not clear the flag.");
  AST_W1_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // R15
    flags_ff[`PEDF_BIT_SEQ] |=> flags_ff[`PEDF_BIT_SEQ] ||
    $past(wr && (paddr == `PEDF_OFF_FLAGS) && !pwdata[`PEDF_BIT_SEQ]))
    else $error("Flag dropped without a zero write.");
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (flags_ff[25:15] == '0) && !flags_ff[28] && (flags_ff[11:0] == '0))
    else $error("Reserved flag bit is set.");
endmodule

// ==== src/pedf_cfg.svh ====
// Offsets, field positions, reset values and counts for the port error-detect flag block.
`ifndef PEDF_CFG_SVH
`define PEDF_CFG_SVH

`define PEDF_OFF_FLAGS 8'h00
`define PEDF_OFF_ACKID 8'h04
`define PEDF_OFF_TMO 8'h08
`define PEDF_OFF_CAPT 8'h0c
`define PEDF_OFF_CAPV 8'h10
`define PEDF_OFF_ISTAT 8'h14
`define PEDF_OFF_ICLR 8'h18
`define PEDF_OFF_IEN 8'h1c
`define PEDF_OFF_CTRL 8'h20

`define PEDF_BIT_SEQ 12
`define PEDF_BIT_CRC 13
`define PEDF_BIT_SIZE 14
`define PEDF_BIT_RSEQ 26
`define PEDF_BIT_UNEXP 27
`define PEDF_BIT_FRAME 29
`define PEDF_BIT_STRAY 30
`define PEDF_BIT_TMO 31
`define PEDF_FLAG_MASK 32'hec007000

`define PEDF_RST_WORD 32'h0000_0000
`define PEDF_RST_TMO 24'h00_1000
`define PEDF_MAX_PKT_BYTES 12'h114
`define PEDF_ACKID_W 5
`define PEDF_TMO_W 24
`define PEDF_LEN_W 12

`endif

// ==== src/pedf_pkg.sv ====
// Types shared by the port error-detect flag block.
package pedf_pkg;
  typedef enum logic [2:0] {
    PEDF_IDLE = 3'b001,
    PEDF_WAIT_RSP = 3'b010,
    PEDF_HALT = 3'b100
  } pedf_rcv_state_t;
endpackage

// ==== src/pedf_ack_if.sv ====
// Signals between the register bank and the ackID tracker.
`timescale 1ns/100ps
`include "pedf_cfg.svh"
interface pedf_ack_if;
  logic tx_sent;
  logic ack_accepted;
  logic rsp_valid;
  logic [`PEDF_ACKID_W-1:0] rsp_ackid;
  logic sw_load;
  logic [`PEDF_ACKID_W-1:0] sw_ackid;
  logic recover_kick;
  logic [`PEDF_TMO_W-1:0] tmo_val;
  logic [`PEDF_ACKID_W-1:0] acked;
  logic [`PEDF_ACKID_W-1:0] next_tx;
  logic halted;
  logic awaiting;
  logic rsp_bad;
  logic ack_stray;
  logic tmo_exp;
  logic link_req;
  modport bank (output tx_sent, ack_accepted, rsp_valid, rsp_ackid, sw_load, sw_ackid,
    recover_kick, tmo_val, input acked, next_tx, halted, awaiting, rsp_bad, ack_stray,
    tmo_exp, link_req);
  modport trk (input tx_sent, ack_accepted, rsp_valid, rsp_ackid, sw_load, sw_ackid,
    recover_kick, tmo_val, output acked, next_tx, halted, awaiting, rsp_bad, ack_stray,
    tmo_exp, link_req);
endinterface

// ==== src/pedf_ack_trk.sv ====
// Transmit ackID tracking, recovery sequencing and acknowledge timeout.
`timescale 1ns/100ps
`include "pedf_cfg.svh"
module pedf_ack_trk
  import pedf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pedf_ack_if.trk t
);
  pedf_rcv_state_t st_ff;
  pedf_rcv_state_t nxt_st;
  logic [`PEDF_ACKID_W-1:0] acked_ff;
  logic [`PEDF_ACKID_W-1:0] next_ff;
  logic [`PEDF_TMO_W-1:0] cnt_ff;
  logic link_req_ff;
  logic [`PEDF_ACKID_W-1:0] outstanding;
  logic [`PEDF_ACKID_W-1:0] rsp_dist;
  logic rsp_bad;
  logic running;
  logic expire;

  assign outstanding = next_ff - acked_ff;
  assign rsp_dist = t.rsp_ackid - acked_ff;
  // The partner may only name an ackID from the oldest unacknowledged up to the next new one.
  assign rsp_bad = t.rsp_valid && (st_ff == PEDF_WAIT_RSP) && (rsp_dist > outstanding); // R04
  assign running = (st_ff == PEDF_WAIT_RSP) || (outstanding != '0);
  assign expire = running && (t.tmo_val != '0) && (cnt_ff >= t.tmo_val - 1'b1);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PEDF_IDLE: begin
        if (t.recover_kick) begin
          nxt_st = PEDF_WAIT_RSP;
        end
      end
      PEDF_WAIT_RSP: begin
        if (rsp_bad) begin
          nxt_st = PEDF_HALT; // R09
        end else if (t.rsp_valid) begin
          nxt_st = PEDF_IDLE;
        end
      end
      PEDF_HALT: begin
        if (t.sw_load) begin
          nxt_st = PEDF_IDLE;
        end
      end
      default: nxt_st = PEDF_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= PEDF_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A link request goes out on entry to recovery and again after each silent timeout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_req_ff <= 1'b0;
    end else begin
      link_req_ff <= ((st_ff == PEDF_IDLE) && t.recover_kick) ||
        ((st_ff == PEDF_WAIT_RSP) && expire && !t.rsp_valid); // R06
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acked_ff <= '0;
      next_ff <= '0;
    end else if (t.sw_load) begin
      acked_ff <= t.sw_ackid;
      next_ff <= t.sw_ackid;
    end else if (t.rsp_valid && (st_ff == PEDF_WAIT_RSP) && !rsp_bad) begin
      acked_ff <= t.rsp_ackid;
      next_ff <= t.rsp_ackid;
    end else begin
      if (t.ack_accepted && (outstanding != '0)) begin
        acked_ff <= acked_ff + 1'b1; // R08
      end
      if (t.tx_sent && (st_ff == PEDF_IDLE)) begin
        next_ff <= next_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (!running || expire || t.ack_accepted || t.rsp_valid) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign t.acked = acked_ff;
  assign t.next_tx = next_ff;
  assign t.halted = (st_ff == PEDF_HALT);
  assign t.awaiting = (st_ff == PEDF_WAIT_RSP);
  assign t.rsp_bad = rsp_bad;
  assign t.ack_stray = t.ack_accepted && (outstanding == '0);
  assign t.tmo_exp = expire;
  assign t.link_req = link_req_ff;

  AST_LINK_REQ_ON_KICK: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (st_ff == PEDF_IDLE) && t.recover_kick |=> link_req_ff && (st_ff == PEDF_WAIT_RSP))
    else $error("Recovery kick did not send a link request.");
  AST_ACKID_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn) // R08
    t.ack_accepted && (outstanding != '0) && !t.sw_load && !t.rsp_valid
    |=> acked_ff == $past(acked_ff) + 1'b1)
    else $error("Accepted acknowledge did not advance the local ackID.");
  AST_HALT_HOLDS: assert property (@(posedge pclk) disable iff (!presetn) // R09
    rsp_bad |=> (st_ff == PEDF_HALT) && $stable(next_ff))
    else $error("Mismatched link response did not stop transfers.");
endmodule

// ==== dv/pedf_link_partner.sv ====
// Behavioural link partner that acknowledges packets and answers link requests.
`timescale 1ns/100ps
module pedf_link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_pkt_sent,
  input wire logic link_req,
  input wire logic ack_en,
  input wire logic [4:0] rsp_skew,
  output logic rx_ack_accepted,
  output logic rx_link_rsp,
  output logic [4:0] rx_link_rsp_ackid,
  output logic [7:0] req_cnt
);
  logic [1:0] ack_pipe_ff;
  logic [4:0] expect_ff;
  logic [3:0] rsp_wait_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Packets are accepted a few cycles after they leave, unless the bench stalls acks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_pipe_ff <= 2'h0;
      rx_ack_accepted <= 1'b0;
      expect_ff <= 5'h00;
    end else begin
      ack_pipe_ff <= {ack_pipe_ff[0], tx_pkt_sent & ack_en};
      rx_ack_accepted <= ack_pipe_ff[1];
      if (ack_pipe_ff[1]) begin
        expect_ff <= expect_ff + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outside a response the ackID lines toggle so a stale value is never mistaken for data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_wait_ff <= 4'h0;
      rx_link_rsp <= 1'b0;
      rx_link_rsp_ackid <= 5'h00;
      req_cnt <= 8'h00;
    end else begin
      if (link_req) begin
        rsp_wait_ff <= 4'h6;
        req_cnt <= req_cnt + 8'h01;
      end else if (rsp_wait_ff != 4'h0) begin
        rsp_wait_ff <= rsp_wait_ff - 4'h1;
      end
      rx_link_rsp <= (rsp_wait_ff == 4'h1);
      rx_link_rsp_ackid <= (rsp_wait_ff == 4'h1) ? expect_ff + rsp_skew : ~rx_link_rsp_ackid;
    end
  end
endmodule

// ==== dv/port_error_detect_flags_test.sv ====
// Register-level testbench for the port error-detect flag block.
`timescale 1ns/100ps
`include "pedf_cfg.svh"
module port_error_detect_flags_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] evs = 6'h00;
  logic [11:0] pbytes = 12'h040;
  logic [31:0] pinfo = 32'h0;
  logic tx_sent = 1'b0;
  logic ack_en = 1'b1;
  logic [4:0] skew = 5'h00;
  logic ack_acc, lrsp, lreq, tx_halt, irq, last_err;
  logic [4:0] lrsp_id;
  logic [7:0] req_cnt;
  logic [31:0] error_flags, q, acc;
  logic [7:0] req0;
  int error_cnt = 0;
  int total_checks = 0;
  logic [5:0] ev_tab [6] = '{6'h01, 6'h03, 6'h05, 6'h08, 6'h10, 6'h20};
  int bit_tab [6] = '{14, 12, 13, 27, 29, 30};

  always #2.5 pclk = ~pclk;

  pedf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pkt_end(evs[0]), .rx_pkt_ackid_bad(evs[1]),
    .rx_pkt_crc_bad(evs[2]), .rx_pkt_bytes(pbytes), .rx_pkt_info(pinfo),
    .rx_symbol_unexpected(evs[3]), .rx_framing_bad(evs[4]), .rx_ack_unexpected(evs[5]),
    .tx_pkt_sent(tx_sent), .rx_ack_accepted(ack_acc), .rx_link_rsp(lrsp),
    .rx_link_rsp_ackid(lrsp_id), .link_req(lreq), .tx_halt(tx_halt),
    .error_flags(error_flags), .irq(irq));

  pedf_link_partner partner (.pclk(pclk), .presetn(presetn), .tx_pkt_sent(tx_sent),
    .link_req(lreq), .ack_en(ack_en), .rsp_skew(skew), .rx_ack_accepted(ack_acc),
    .rx_link_rsp(lrsp), .rx_link_rsp_ackid(lrsp_id), .req_cnt(req_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; the access is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic fire(input logic [5:0] v, input logic [11:0] b, input logic [31:0] info);
    evs <= v;
    pbytes <= b;
    pinfo <= info;
    @(posedge pclk);
    evs <= 6'h00;
    @(posedge pclk);
  endtask

  task automatic send_pkt();
    tx_sent <= 1'b1;
    @(posedge pclk);
    tx_sent <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `PEDF_OFF_TMO, 32'h0);
    chk(q, 32'h0000_1000);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk1(last_err, 1'b1);
    // A packet of exactly the limit is legal.
    fire(6'h01, 12'h114, 32'h0);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    acc = 32'h0;
    for (int k = 0; k < 6; k++) begin
      fire(ev_tab[k], (k == 0) ? 12'h115 : 12'h040, 32'h0a00_0000 + k);
      acc = acc | (32'h1 << bit_tab[k]);
      apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
      chk(q, acc);
      chk(error_flags, acc);
    end
    apb(1'b0, `PEDF_OFF_CAPT, 32'h0);
    chk(q, 32'h0a00_0002);
    apb(1'b1, `PEDF_OFF_FLAGS, 32'hffff_efff);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, acc & 32'hffff_efff);
    apb(1'b1, `PEDF_OFF_FLAGS, 32'h0);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    // Interrupt raised, cleared, then masked.
    apb(1'b1, `PEDF_OFF_ICLR, 32'hffff_ffff);
    apb(1'b1, `PEDF_OFF_IEN, 32'h0000_2000);
    fire(6'h05, 12'h040, 32'h0);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b1);
    apb(1'b1, `PEDF_OFF_ICLR, 32'h0000_2000);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    apb(1'b1, `PEDF_OFF_IEN, 32'h0);
    fire(6'h05, 12'h040, 32'h0);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    apb(1'b0, `PEDF_OFF_ISTAT, 32'h0);
    chk(q & 32'h0000_2000, 32'h0000_2000);
    apb(1'b0, `PEDF_OFF_ICLR, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `PEDF_OFF_FLAGS, 32'h0);
    // Accepted packets advance the local ackID.
    repeat (3) send_pkt();
    apb(1'b0, `PEDF_OFF_ACKID, 32'h0);
    chk(q, 32'h0000_0303);
    req0 = req_cnt;
    apb(1'b1, `PEDF_OFF_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk({24'h0, req_cnt}, {24'h0, req0 + 8'h01});
    chk1(tx_halt, 1'b1);
    repeat (12) @(posedge pclk);
    chk1(tx_halt, 1'b0);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    // A short timeout resends the link request; the second answer lands outside recovery.
    apb(1'b1, `PEDF_OFF_TMO, 32'h0000_0006);
    apb(1'b1, `PEDF_OFF_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    chk({24'h0, req_cnt}, {24'h0, req0 + 8'h03});
    chk1(tx_halt, 1'b0);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h8800_0000);
    apb(1'b1, `PEDF_OFF_FLAGS, 32'h0);
    apb(1'b1, `PEDF_OFF_TMO, 32'h0000_1000);
    // The partner now names an ackID that was never sent.
    skew <= 5'h03;
    apb(1'b1, `PEDF_OFF_CTRL, 32'h1);
    repeat (16) @(posedge pclk);
    chk1(tx_halt, 1'b1);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0400_0000);
    apb(1'b0, `PEDF_OFF_ACKID, 32'h0);
    chk(q & 32'h0001_0000, 32'h0001_0000);
    apb(1'b0, `PEDF_OFF_CAPV, 32'h0);
    chk(q & 32'h1, 32'h0);
    skew <= 5'h00;
    apb(1'b1, `PEDF_OFF_ACKID, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    chk1(tx_halt, 1'b0);
    apb(1'b0, `PEDF_OFF_ACKID, 32'h0);
    chk(q, 32'h0000_0606);
    // A packet left unacknowledged expires after the programmed count.
    apb(1'b1, `PEDF_OFF_FLAGS, 32'h0);
    apb(1'b1, `PEDF_OFF_TMO, 32'h0000_0010);
    ack_en <= 1'b0;
    send_pkt();
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PEDF_OFF_FLAGS, 32'h0);
    chk(q & 32'h8000_0000, 32'h8000_0000);
    conclude();
  end
endmodule
